// ==== src/clock_cfg_defines.svh ====
// Constants for the clock configuration word decoder
// Operation
// - Decode switch/monitor field: 1x, 01, 00
// - Bus divisor default: 8,4,2,1 per field
// - Clock output only with primary off/external
// - Primary oscillator mode from two-bit field
// - Bit 7 enables two-speed start-up
// - Bit 5 enables secondary oscillator
// - Select codes 111..100: RC and secondary sources
// - Select codes 011..000: primary and fast RC
`ifndef CLOCK_CFG_DEFINES_SVH
`define CLOCK_CFG_DEFINES_SVH
`define CFG_WORD_OFF 12'h000
`define CFG_LATCHED_OFF 12'h004
`define CFG_STATUS_OFF 12'h008
`define FLD_FCS_HI 15
`define FLD_FCS_LO 14
`define FLD_DIV_HI 13
`define FLD_DIV_LO 12
`define FLD_RSV11 11
`define FLD_CLKOUT_DIS 10
`define FLD_PMODE_HI 9
`define FLD_PMODE_LO 8
`define FLD_TWO_SPEED 7
`define FLD_RSV6 6
`define FLD_SEC_EN 5
`define FLD_RSV_HI 4
`define FLD_RSV_LO 3
`define FLD_SEL_HI 2
`define FLD_SEL_LO 0
`define RSV_MASK 32'h0000_0858
`define CFG_WORD_RESET 32'hffff_ffff
`endif

// ==== src/clock_cfg_pkg.sv ====
// Types for the clock configuration word decoder
package clock_cfg_pkg;
   typedef enum logic [1:0] {POSC_EXT, POSC_XT, POSC_HS, POSC_OFF} posc_mode_e;
   typedef enum logic [2:0] {SRC_FAST_RC, SRC_FAST_RC_DIV_PLL, SRC_POSC, SRC_POSC_PLL,
                             SRC_SOSC, SRC_LOW_POWER_RC, SRC_FAST_RC_DIV16,
                             SRC_FAST_RC_DIV} osc_src_e;
   typedef enum logic [1:0] {DIV_1, DIV_2, DIV_4, DIV_8} pb_div_e;
   typedef enum {ST_RESET, ST_CAPTURE, ST_HOLD} cap_state_e;
endpackage

// ==== src/cfg_field_decode.sv ====
// Combinational decode of the clock configuration word
`timescale 1ns/1ps
module cfg_field_decode
   import clock_cfg_pkg::*;
(
   input wire logic [31:0] word,
   output logic switch_en,
   output logic monitor_en,
   output clock_cfg_pkg::pb_div_e pb_div,
   output logic [3:0] pb_div_ratio,
   output clock_cfg_pkg::posc_mode_e posc_mode,
   output logic clock_out_en,
   output logic two_speed_en,
   output logic sec_en,
   output clock_cfg_pkg::osc_src_e osc_src,
   output logic cfg_fault
);
   import clock_cfg_pkg::*;
`include "clock_cfg_defines.svh"
   always_comb begin
      switch_en = ~word[`FLD_FCS_HI];
      monitor_en = ~word[`FLD_FCS_HI] & ~word[`FLD_FCS_LO];
      pb_div = pb_div_e'(word[`FLD_DIV_HI:`FLD_DIV_LO]);
      pb_div_ratio = 4'h1 << word[`FLD_DIV_HI:`FLD_DIV_LO];
      posc_mode = posc_mode_e'(word[`FLD_PMODE_HI:`FLD_PMODE_LO]);
      // output only when primary off or external
      clock_out_en = ~word[`FLD_CLKOUT_DIS] & (posc_mode == POSC_OFF || posc_mode == POSC_EXT);
      two_speed_en = word[`FLD_TWO_SPEED];
      sec_en = word[`FLD_SEC_EN];
      osc_src = osc_src_e'(word[`FLD_SEL_HI:`FLD_SEL_LO]);
      // flag a word the programmer got wrong
      cfg_fault = ((word & `RSV_MASK) != `RSV_MASK) ||
                  (posc_mode == POSC_OFF && osc_src == SRC_POSC);
   end
endmodule

// ==== src/clock_config_word_decode.sv ====
// APB-visible capture and decode of the clock configuration word
`timescale 1ns/1ps
module clock_config_word_decode
   import clock_cfg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [31:0] cfg_word_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic switch_en,
   output logic monitor_en,
   output clock_cfg_pkg::pb_div_e periph_bus_div_default,
   output logic [3:0] pb_div_ratio,
   output clock_cfg_pkg::posc_mode_e primary_osc_mode,
   output logic clock_output_en,
   output logic two_speed_startup_en,
   output logic secondary_osc_en,
   output clock_cfg_pkg::osc_src_e startup_osc_sel,
   output logic cfg_fault,
   output logic cfg_valid
);
   import clock_cfg_pkg::*;
`include "clock_cfg_defines.svh"

   // ***************************************
   // Capture of the word at reset release
   // ***************************************
   cap_state_e state_q, state_d;
   logic [31:0] word_q, word_d;
   logic [31:0] prdata_q, prdata_d;
   logic sw_d, mon_d, clk_out_d, ts_d, sec_d, flt_d;
   pb_div_e div_d;
   logic [3:0] ratio_d;
   posc_mode_e pm_d;
   osc_src_e src_d;
   logic valid_q;

   // Word is static while reset is held, so one clocked sample is enough
   always_comb begin
      state_d = state_q;
      word_d = word_q;
      case (state_q)
         ST_RESET: state_d = ST_CAPTURE;
         ST_CAPTURE: begin
            word_d = cfg_word_in;
            state_d = ST_HOLD;
         end
         ST_HOLD: state_d = ST_HOLD;
         default: state_d = ST_RESET;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_RESET;
         word_q <= `CFG_WORD_RESET;
      end else begin
         state_q <= state_d;
         word_q <= word_d;
      end
   end

   cfg_field_decode u_dec (
      .word(word_q),
      .switch_en(sw_d),
      .monitor_en(mon_d),
      .pb_div(div_d),
      .pb_div_ratio(ratio_d),
      .posc_mode(pm_d),
      .clock_out_en(clk_out_d),
      .two_speed_en(ts_d),
      .sec_en(sec_d),
      .osc_src(src_d),
      .cfg_fault(flt_d)
   );

   // Outputs registered so they never glitch while the word settles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_en <= 1'b0;
         monitor_en <= 1'b0;
         periph_bus_div_default <= DIV_8;
         pb_div_ratio <= 4'h8;
         primary_osc_mode <= POSC_OFF;
         clock_output_en <= 1'b0;
         two_speed_startup_en <= 1'b0;
         secondary_osc_en <= 1'b0;
         startup_osc_sel <= SRC_FAST_RC;
         cfg_fault <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         switch_en <= sw_d;
         monitor_en <= mon_d;
         periph_bus_div_default <= div_d;
         pb_div_ratio <= ratio_d;
         primary_osc_mode <= pm_d;
         clock_output_en <= clk_out_d;
         two_speed_startup_en <= ts_d;
         secondary_osc_en <= sec_d;
         startup_osc_sel <= src_d;
         cfg_fault <= flt_d;
         valid_q <= (state_q == ST_HOLD);
      end
   end
   assign cfg_valid = valid_q;

   // ***************************************
   // APB slave, read only, zero wait
   // ***************************************
   logic setup;
   assign setup = psel & ~penable;
   assign pready = 1'b1;
   // Writes and unmapped addresses answer with an error
   assign pslverr = psel & penable & (pwrite ||
      !(paddr == `CFG_WORD_OFF || paddr == `CFG_LATCHED_OFF || paddr == `CFG_STATUS_OFF));

   always_comb begin
      prdata_d = prdata_q;
      if (setup && !pwrite) begin
         case (paddr)
            `CFG_WORD_OFF: prdata_d = word_q;
            `CFG_LATCHED_OFF: prdata_d = {19'h0, sec_d, ts_d, clk_out_d,
                                          2'(pm_d), 2'(div_d), sw_d, mon_d, 3'(src_d),
                                          1'b0};
            `CFG_STATUS_OFF: prdata_d = {30'h0, cfg_fault, valid_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end
   assign prdata = prdata_q;

   // ***************************************
   // Checks
   // ***************************************
   logic [31:0] w;
   assign w = word_q;

   sequence s_held;
      valid_q ##1 valid_q;
   endsequence

   sequence s_in_reset;
      !presetn ##1 !presetn;
   endsequence

   sequence s_released;
      $rose(state_q == ST_CAPTURE);
   endsequence

   sequence s_settle;
      (state_q == ST_HOLD) ##1 valid_q;
   endsequence

   chk_monitor_needs_sw: assert property (@(posedge pclk) disable iff (!presetn)
      valid_q |-> (monitor_en == (w[15:14] == 2'b00) && switch_en == !w[15]))
      else $error("switch/monitor decode wrong");
   chk_div_ratio: assert property (@(posedge pclk) disable iff (!presetn)
      valid_q |-> pb_div_ratio == (4'h1 << w[13:12]))
      else $error("bus divisor wrong");
   chk_clkout_gate: assert property (@(posedge pclk) disable iff (!presetn)
      valid_q |-> clock_output_en == (!w[10] && (w[9:8] == 2'b11 || w[9:8] == 2'b00)))
      else $error("clock output gating wrong");
   chk_posc_mode: assert property (@(posedge pclk) disable iff (!presetn)
      valid_q |-> 2'(primary_osc_mode) == w[9:8])
      else $error("primary mode wrong");
   chk_two_speed: assert property (@(posedge pclk) disable iff (!presetn)
      valid_q |-> two_speed_startup_en == w[7])
      else $error("two-speed wrong");
   chk_sec_osc: assert property (@(posedge pclk) disable iff (!presetn)
      valid_q |-> secondary_osc_en == w[5])
      else $error("secondary enable wrong");
   chk_src_upper: assert property (@(posedge pclk) disable iff (!presetn)
      (valid_q && w[2]) |-> 3'(startup_osc_sel) == w[2:0])
      else $error("upper source wrong");
   chk_src_lower: assert property (@(posedge pclk) disable iff (!presetn)
      (valid_q && !w[2]) |-> 3'(startup_osc_sel) == w[2:0])
      else $error("lower source wrong");
   chk_fault_flag: assert property (@(posedge pclk) disable iff (!presetn)
      valid_q |-> cfg_fault == (((w & `RSV_MASK) != `RSV_MASK) ||
                                (w[9:8] == 2'b11 && w[2:0] == 3'b010)))
      else $error("fault flag wrong");
   chk_hold_stable: assert property (@(posedge pclk) disable iff (!presetn)
      s_held |-> $stable(w) && $stable(startup_osc_sel))
      else $error("word changed after capture");
   chk_valid_time: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_q == ST_HOLD) |=> valid_q)
      else $error("valid late");
   chk_word_taken: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_q == ST_HOLD) |-> w == $past(cfg_word_in))
      else $error("captured word differs from input");
   chk_capture_steps: assert property (@(posedge pclk) disable iff (!presetn)
      s_released |=> s_settle)
      else $error("capture steps out of order");
   // quiet during reset
   // Checked from the second low edge, once the flops have surely been cleared
   chk_reset_quiet: assert property (@(posedge pclk)
      s_in_reset |-> !cfg_valid && !switch_en && !clock_output_en)
      else $error("outputs live in reset");
   chk_write_refused: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite) |-> pslverr)
      else $error("write not refused");
endmodule

// ==== bench/clock_config_word_decode_bench.sv ====
// Self-checking bench for the clock configuration word decoder
`timescale 1ns/1ps
module clock_config_word_decode_bench;
   import clock_cfg_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, cfg_word_in = 32'hffff_ffff, lfsr = 32'h3, rd, prdata;
   logic pready, pslverr, switch_en, monitor_en, clock_output_en, two_speed_startup_en;
   logic secondary_osc_en, cfg_fault, cfg_valid, err;
   logic [3:0] pb_div_ratio;
   pb_div_e periph_bus_div_default;
   posc_mode_e primary_osc_mode;
   osc_src_e startup_osc_sel;
   int failures = 0;
   int comparisons = 0;

   always #12.5 pclk = ~pclk;

   clock_config_word_decode u_clock_config_word_decode (
      .pclk(pclk), .presetn(presetn), .cfg_word_in(cfg_word_in), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .switch_en(switch_en), .monitor_en(monitor_en),
      .periph_bus_div_default(periph_bus_div_default), .pb_div_ratio(pb_div_ratio),
      .primary_osc_mode(primary_osc_mode), .clock_output_en(clock_output_en),
      .two_speed_startup_en(two_speed_startup_en), .secondary_osc_en(secondary_osc_en),
      .startup_osc_sel(startup_osc_sel), .cfg_fault(cfg_fault), .cfg_valid(cfg_valid));

   // ****************
   // Helpers
   // ****************
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] step(input logic [31:0] s);
      step = {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
   endfunction

   // Decoded image as the 0x004 register lays it out
   function automatic logic [31:0] dec_img(input logic [31:0] w);
      logic co;
      co = ~w[10] & (w[9:8] == 2'b11 || w[9:8] == 2'b00);
      dec_img = {19'h0, w[5], w[7], co, w[9:8], w[13:12], ~w[15], ~w[15] & ~w[14], w[2:0], 1'b0};
   endfunction

   function automatic logic fault_exp(input logic [31:0] w);
      fault_exp = ((w & 32'h0000_0858) != 32'h0000_0858) || (w[9:8] == 2'b11 && w[2:0] == 3'b010);
   endfunction

   task automatic apb(input logic wr, input logic [11:0] a, output logic [31:0] d,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= lfsr;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends once pready, psel and penable are seen high; the watchdog bounds this wait
      do begin
         @(posedge pclk);
      end while (!(pready === 1'b1 && psel === 1'b1 && penable === 1'b1));
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ****************
   // One configuration word
   // ****************
   task automatic run_word(input logic [31:0] w);
      logic [31:0] img;
      img = dec_img(w);
      @(posedge pclk);
      presetn <= 1'b0;
      cfg_word_in <= w;
      repeat (4) @(posedge pclk);
      cmp({20'h0, switch_en, monitor_en, periph_bus_div_default, pb_div_ratio,
           primary_osc_mode, clock_output_en, cfg_valid}, 32'h0000_038c);
      presetn <= 1'b1;
      // Ends once cfg_valid is seen high; the watchdog bounds this wait
      while (cfg_valid !== 1'b1) begin
         @(posedge pclk);
         #1;
      end
      cmp({30'h0, switch_en, monitor_en}, {30'h0, img[5:4]});
      cmp({26'h0, periph_bus_div_default, pb_div_ratio},
          {26'h0, w[13:12], 4'h1 << w[13:12]});
      cmp({31'h0, clock_output_en}, {31'h0, img[10]});
      cmp({30'h0, primary_osc_mode}, {30'h0, w[9:8]});
      cmp({30'h0, two_speed_startup_en, secondary_osc_en}, {30'h0, w[7], w[5]});
      cmp({29'h0, startup_osc_sel}, {29'h0, w[2:0]});
      cmp({31'h0, cfg_fault}, {31'h0, fault_exp(w)});
      // Word moves after capture; nothing may follow it
      @(posedge pclk);
      cfg_word_in <= ~w;
      apb(1'b0, 12'h000, rd, err);
      cmp(rd, w);
      cmp({31'h0, err}, 32'h0);
      apb(1'b0, 12'h004, rd, err);
      cmp(rd, img);
      apb(1'b0, 12'h008, rd, err);
      cmp(rd, {30'h0, fault_exp(w), 1'b1});
      apb(1'b1, 12'h000, rd, err);
      cmp({31'h0, err}, 32'h1);
      apb(1'b0, 12'h000, rd, err);
      cmp(rd, w);
      apb(1'b0, 12'h00c, rd, err);
      cmp({31'h0, err}, 32'h1);
      cmp(rd, 32'h0);
      cmp({29'h0, startup_osc_sel}, {29'h0, w[2:0]});
      $display("test done word=%h", w);
   endtask

   task report_and_stop;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ****************
   // Sequence and watchdog
   // ****************
   initial begin
      run_word(32'hffff_ffff);
      run_word(32'h0000_0000);
      run_word(32'h0000_0b5a);
      run_word(32'h0000_4a59);
      // Every select code once, every mode and divisor code twice
      for (int i = 0; i < 8; i++) begin
         lfsr = step(lfsr);
         run_word({lfsr[31:16], lfsr[15:14], ~i[1:0], lfsr[11:10], i[1:0], lfsr[7:3], i[2:0]});
      end
      report_and_stop;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      report_and_stop;
   end
endmodule
